// ---- inc/pmc_pkg.sv ----
// Package for the power mode controller: modes, field positions, counts.
// Assumes a single system clock domain at 100 MHz.
package pmc_pkg;

    localparam int unsigned PMC_NUM_MODES     = 5;
    localparam int unsigned PMC_NUM_WAKE      = 4;
    // Wake flag bit positions inside the wake configuration byte.
    localparam int unsigned WK_CMP_RISE       = 0;
    localparam int unsigned WK_PORT_MATCH     = 1;
    localparam int unsigned WK_RTC_ALARM      = 2;
    localparam int unsigned WK_RTC_OSC_FAIL   = 3;
    localparam int unsigned WK_RST_PIN        = 4;
    // Power control bit positions.
    localparam int unsigned PC_IDLE_BIT       = 0;
    localparam int unsigned PC_STOP_BIT       = 1;
    localparam logic [4:0]  WAKE_FLAGS_RESET  = 5'h00;
    localparam logic [15:0] RESET_VECTOR      = 16'h0000;
    // Blanking of wake flags after a suspend exit, in system clocks.
    localparam int unsigned FLAG_BLANK_CLKS   = 2;
    // Software hold-off after a reset-pin wake-up.
    localparam int unsigned RST_WAKE_HOLD_US  = 15;
    localparam int unsigned CLK_MHZ           = 100;
    localparam int unsigned RST_WAKE_HOLD_CLKS =
        RST_WAKE_HOLD_US * CLK_MHZ;

    typedef enum logic [4:0] {
        PMC_NORMAL  = 5'h01,
        PMC_IDLE    = 5'h02,
        PMC_STOP    = 5'h04,
        PMC_SUSPEND = 5'h08,
        PMC_SLEEP   = 5'h10
    } pmc_mode_e;

    // Mode request strobes written by the CPU core.
    typedef struct packed {
        logic idle;
        logic stop;
        logic suspend;
        logic sleep;
    } pmc_req_s;

    // Raw wake-up events from peripherals.
    typedef struct packed {
        logic rtc_osc_fail;
        logic rtc_alarm;
        logic port_match;
        logic cmp_rise;
    } pmc_wake_s;

endpackage

// ---- design/pmc_sync.sv ----
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes the inputs are quasi-static relative to the system clock.
`timescale 1ns/1ps
module pmc_sync
    import pmc_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = meta_reg;
        sync_next = sync_reg;
        if (i_ce) begin
            meta_next = i_async;
            sync_next = meta_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg;
endmodule

// ---- design/pmc_wake_flags.sv ----
// Sticky wake-up flags with software clear and post-suspend read blanking.
// Assumes event inputs are synchronous single-clock pulses or levels.
`timescale 1ns/1ps
module pmc_wake_flags
    import pmc_pkg::*;
(
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire logic                    i_ce,
    input  wire logic [PMC_NUM_WAKE:0]   i_event,
    input  wire logic                    i_clear,
    input  wire logic                    i_blank_start,
    output logic      [PMC_NUM_WAKE:0]   o_flags,
    output logic      [PMC_NUM_WAKE:0]   o_flags_visible
);
    logic [PMC_NUM_WAKE:0] flags_reg;
    logic [PMC_NUM_WAKE:0] flags_next;
    logic [1:0]            blank_reg;
    logic [1:0]            blank_next;

    always_comb begin
        flags_next = flags_reg;
        blank_next = blank_reg;
        if (i_ce) begin
            // Set beats clear so an event in the clear cycle survives.
            if (i_clear) begin
                flags_next = '0;
            end
            flags_next = flags_next | i_event;
            if (i_blank_start) begin
                blank_next = 2'(FLAG_BLANK_CLKS);
            end else if (blank_reg != 2'h0) begin
                blank_next = blank_reg - 2'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags_reg <= WAKE_FLAGS_RESET;
            blank_reg <= 2'h0;
        end else begin
            flags_reg <= flags_next;
            blank_reg <= blank_next;
        end
    end

    assign o_flags         = flags_reg;
    assign o_flags_visible = (blank_reg != 2'h0) ? '0 : flags_reg;
endmodule

// ---- design/pmc_top.sv ----
// Power mode controller: normal, idle, stop, suspend and sleep sequencing.
// Assumes the CPU core raises request strobes when the writing instruction
// retires, and that wake sources and the reset pin are asynchronous.
`timescale 1ns/1ps
module pmc_top
    import pmc_pkg::*;
(
    input  wire logic                  I_REF_CLK,
    input  wire logic                  I_RST,
    input  wire logic                  I_CE,
    input  wire pmc_req_s              I_MODE_REQ,
    input  wire logic [PMC_NUM_WAKE-1:0] I_WAKE_EN,
    input  wire logic                  I_WAKE_CLEAR,
    input  wire logic                  I_INT_PENDING,
    input  wire logic                  I_WDT_EN,
    input  wire logic                  I_WDT_TIMEOUT,
    input  wire logic                  I_MCD_EN,
    input  wire logic                  I_MCD_TIMEOUT,
    input  wire logic                  I_EXT_RESET,
    input  wire pmc_wake_s             I_WAKE_EVT,
    input  wire logic                  I_RST_PIN_N,
    output pmc_mode_e                  O_MODE,
    output logic                       O_CPU_HALT,
    output logic                       O_CPU_RESET,
    output logic [15:0]                O_RESUME_VECTOR_SEL,
    output logic                       O_IDLE_SEL,
    output logic                       O_STOP_SEL,
    output logic                       O_SYSCLK_GATE,
    output logic                       O_PREC_OSC_EN,
    output logic                       O_LP_OSC_EN,
    output logic                       O_PERIPH_FREEZE,
    output logic                       O_INT_SERVICE,
    output logic [7:0]                 O_WAKE_CONFIG,
    output logic                       O_WAKE_FROM_RST_PIN,
    output logic                       O_SUPPLY_GATE
);
    // Pin and wake-source levels pass two flops before any logic reads them.
    logic [PMC_NUM_WAKE:0] raw_async;
    logic [PMC_NUM_WAKE:0] raw_sync;
    logic [PMC_NUM_WAKE:0] prev_reg;
    logic [PMC_NUM_WAKE:0] prev_next;
    logic [PMC_NUM_WAKE:0] evt;
    logic [PMC_NUM_WAKE:0] flags;
    logic [PMC_NUM_WAKE:0] flags_vis;
    logic                  suspend_exit;

    // Suspend and sleep share clock gating and wake-up handling.
    function automatic logic is_gated(input pmc_mode_e m);
        return (m == PMC_SUSPEND) || (m == PMC_SLEEP);
    endfunction

    assign raw_async = {~I_RST_PIN_N, I_WAKE_EVT.rtc_osc_fail,
                        I_WAKE_EVT.rtc_alarm, I_WAKE_EVT.port_match,
                        I_WAKE_EVT.cmp_rise};

    pmc_sync #(.WIDTH(PMC_NUM_WAKE + 1)) u_sync (
        .i_clk   (I_REF_CLK),
        .i_rst   (I_RST),
        .i_ce    (I_CE),
        .i_async (raw_async),
        .o_sync  (raw_sync)
    );

    // Rising edges only: comparator rise and reset pin falling edge.
    assign evt = raw_sync & ~prev_reg;

    pmc_wake_flags u_flags (
        .i_clk           (I_REF_CLK),
        .i_rst           (I_RST),
        .i_ce            (I_CE),
        .i_event         (evt),
        .i_clear         (I_WAKE_CLEAR),
        .i_blank_start   (suspend_exit),
        .o_flags         (flags),
        .o_flags_visible (flags_vis)
    );

    pmc_mode_e   mode_reg;
    pmc_mode_e   mode_next;
    logic        idle_sel_reg;
    logic        idle_sel_next;
    logic        stop_sel_reg;
    logic        stop_sel_next;
    logic [PMC_NUM_WAKE-1:0] wen_reg;
    logic [PMC_NUM_WAKE-1:0] wen_next;
    logic        rstwk_reg;
    logic        rstwk_next;
    logic        cpu_rst_reg;
    logic        cpu_rst_next;
    logic        int_srv_reg;
    logic        int_srv_next;
    logic [7:0]  cfg_reg;
    logic [7:0]  cfg_next;
    logic        any_reset;
    logic        wake_hit;
    logic        enabled_flag_set;

    // Watchdog and missing clock detector only count when enabled.
    assign any_reset = I_EXT_RESET
                     | (I_WDT_EN & I_WDT_TIMEOUT)
                     | (I_MCD_EN & I_MCD_TIMEOUT);
    // Reset pin edges always wake, even a glitch too short to reset.
    assign wake_hit = (|(evt[PMC_NUM_WAKE-1:0] & wen_reg))
                    | evt[WK_RST_PIN];
    // The reset pin is always a wake source, so its flag blocks entry too.
    assign enabled_flag_set = |(flags & {1'b1, I_WAKE_EN});
    assign suspend_exit = I_CE & wake_hit & is_gated(mode_reg);

    always_comb begin
        mode_next     = mode_reg;
        idle_sel_next = idle_sel_reg;
        stop_sel_next = stop_sel_reg;
        wen_next      = wen_reg;
        rstwk_next    = rstwk_reg;
        cpu_rst_next  = cpu_rst_reg;
        int_srv_next  = int_srv_reg;
        prev_next     = prev_reg;
        if (I_CE) begin
            cpu_rst_next = 1'b0;
            int_srv_next = 1'b0;
            prev_next = raw_sync;
            case (mode_reg)
                PMC_NORMAL: begin
                    // Priority keeps only one low-power mode active.
                    if (I_MODE_REQ.sleep && !enabled_flag_set) begin
                        mode_next = PMC_SLEEP;
                        wen_next  = I_WAKE_EN;
                    end else if (I_MODE_REQ.suspend
                                 && !enabled_flag_set) begin
                        mode_next = PMC_SUSPEND;
                        wen_next  = I_WAKE_EN;
                    end else if (I_MODE_REQ.stop) begin
                        mode_next     = PMC_STOP;
                        stop_sel_next = 1'b1;
                    end else if (I_MODE_REQ.idle) begin
                        mode_next     = PMC_IDLE;
                        idle_sel_next = 1'b1;
                    end
                end
                PMC_IDLE: begin
                    if (I_INT_PENDING) begin
                        mode_next     = PMC_NORMAL;
                        idle_sel_next = 1'b0;
                        int_srv_next  = 1'b1;
                    end
                end
                PMC_STOP: begin
                    // Only the reset path below leaves stop.
                    mode_next = PMC_STOP;
                end
                PMC_SUSPEND, PMC_SLEEP: begin
                    if (wake_hit) begin
                        mode_next  = PMC_NORMAL;
                        rstwk_next = evt[WK_RST_PIN];
                    end
                end
                default: begin
                    mode_next = PMC_NORMAL;
                end
            endcase
            if (any_reset) begin
                mode_next     = PMC_NORMAL;
                idle_sel_next = 1'b0;
                stop_sel_next = 1'b0;
                cpu_rst_next  = 1'b1;
            end
        end
    end

    // Wake configuration byte: mode strobes at the top read zero.
    always_comb begin
        cfg_next = cfg_reg;
        if (I_CE) begin
            cfg_next = 8'h00;
            cfg_next[PMC_NUM_WAKE-1:0] = flags_vis[PMC_NUM_WAKE-1:0];
            // The pin wake flag is blanked with the others after an exit.
            cfg_next[WK_RST_PIN] = flags_vis[WK_RST_PIN];
            if (suspend_exit) begin
                // Old flags must not show in the first clock after a wake.
                cfg_next = 8'h00;
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            mode_reg     <= PMC_NORMAL;
            idle_sel_reg <= 1'b0;
            stop_sel_reg <= 1'b0;
            wen_reg      <= '0;
            rstwk_reg    <= 1'b0;
            cpu_rst_reg  <= 1'b0;
            int_srv_reg  <= 1'b0;
            prev_reg     <= '0;
            cfg_reg      <= 8'h00;
        end else begin
            mode_reg     <= mode_next;
            idle_sel_reg <= idle_sel_next;
            stop_sel_reg <= stop_sel_next;
            wen_reg      <= wen_next;
            rstwk_reg    <= rstwk_next;
            cpu_rst_reg  <= cpu_rst_next;
            int_srv_reg  <= int_srv_next;
            prev_reg     <= prev_next;
            cfg_reg      <= cfg_next;
        end
    end

    // Outputs other than vec_reg, which holds RESET_VECTOR, decode mode_next into flops, so they change on the same edge as the mode register.
    logic halt_reg;
    logic gate_reg;
    logic prec_reg;
    logic lp_reg;
    logic frz_reg;
    logic supply_reg;
    logic halt_next;
    logic gate_next;
    logic prec_next;
    logic lp_next;
    logic frz_next;
    logic supply_next;
    logic [15:0] vec_reg;
    logic [15:0] vec_next;

    always_comb begin
        halt_next   = halt_reg;
        gate_next   = gate_reg;
        prec_next   = prec_reg;
        lp_next     = lp_reg;
        frz_next    = frz_reg;
        supply_next = supply_reg;
        vec_next    = vec_reg;
        if (I_CE) begin
            // Idle only halts the CPU; peripherals and memory keep state.
            halt_next   = (mode_next != PMC_NORMAL);
            gate_next   = is_gated(mode_next);
            frz_next    = gate_next;
            // Stop leaves the low-power oscillator as it was.
            prec_next   = !((mode_next == PMC_STOP) || gate_next);
            lp_next     = !gate_next;
            supply_next = (mode_next == PMC_SLEEP);
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            halt_reg   <= 1'b0;
            gate_reg   <= 1'b0;
            prec_reg   <= 1'b1;
            lp_reg     <= 1'b1;
            frz_reg    <= 1'b0;
            supply_reg <= 1'b0;
            vec_reg    <= RESET_VECTOR;
        end else begin
            halt_reg   <= halt_next;
            gate_reg   <= gate_next;
            prec_reg   <= prec_next;
            lp_reg     <= lp_next;
            frz_reg    <= frz_next;
            supply_reg <= supply_next;
            vec_reg    <= vec_next;
        end
    end

    assign O_MODE              = mode_reg;
    assign O_CPU_HALT          = halt_reg;
    assign O_CPU_RESET         = cpu_rst_reg;
    assign O_RESUME_VECTOR_SEL = vec_reg;
    assign O_IDLE_SEL          = idle_sel_reg;
    assign O_STOP_SEL          = stop_sel_reg;
    assign O_SYSCLK_GATE       = gate_reg;
    assign O_PREC_OSC_EN       = prec_reg;
    assign O_LP_OSC_EN         = lp_reg;
    assign O_PERIPH_FREEZE     = frz_reg;
    assign O_INT_SERVICE       = int_srv_reg;
    assign O_WAKE_CONFIG       = cfg_reg;
    assign O_WAKE_FROM_RST_PIN = rstwk_reg;
    assign O_SUPPLY_GATE       = supply_reg;
endmodule

// ---- sim/pmc_asserts.sv ----
// Concurrent checks on the ports of the power mode controller top.
// Assumes it is bound to pmc_top and shares its single clock and reset.
`timescale 1ns/1ps
module pmc_asserts
    import pmc_pkg::*;
(
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RST,
    input  wire logic       I_CE,
    input  wire pmc_req_s   I_MODE_REQ,
    input  wire logic       I_INT_PENDING,
    input  wire logic       I_WDT_EN,
    input  wire logic       I_WDT_TIMEOUT,
    input  wire logic       I_MCD_EN,
    input  wire logic       I_MCD_TIMEOUT,
    input  wire logic       I_EXT_RESET,
    input  wire pmc_mode_e  O_MODE,
    input  wire logic       O_CPU_HALT,
    input  wire logic       O_CPU_RESET,
    input  wire logic       O_IDLE_SEL,
    input  wire logic       O_SYSCLK_GATE,
    input  wire logic       O_PREC_OSC_EN,
    input  wire logic       O_LP_OSC_EN,
    input  wire logic       O_PERIPH_FREEZE,
    input  wire logic       O_INT_SERVICE,
    input  wire logic [7:0] O_WAKE_CONFIG,
    input  wire logic       O_SUPPLY_GATE
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    logic any_rst;
    // Timeouts only count as resets when their source is enabled.
    assign any_rst = I_EXT_RESET || (I_WDT_EN && I_WDT_TIMEOUT)
                     || (I_MCD_EN && I_MCD_TIMEOUT);
    sequence idle_taken;
        O_MODE == PMC_NORMAL && I_CE && I_MODE_REQ == 4'h8 && !any_rst;
    endsequence
    sequence int_exit;
        O_MODE == PMC_IDLE && I_CE && I_INT_PENDING && !any_rst;
    endsequence
    sequence wake_exit;
        $past(O_MODE) inside {PMC_SUSPEND, PMC_SLEEP} && O_MODE == PMC_NORMAL;
    endsequence
    a_idle_entry: assert property (idle_taken |=>
        O_MODE == PMC_IDLE && O_IDLE_SEL && O_CPU_HALT)
        else $error("Idle request did not halt the core.");
    a_int_exit: assert property (int_exit |=> O_MODE == PMC_NORMAL
        && !O_IDLE_SEL && O_INT_SERVICE ##1 !O_INT_SERVICE)
        else $error("Interrupt exit from idle wrong.");
    a_reset_exit: assert property (O_MODE inside {PMC_IDLE, PMC_STOP}
        && I_CE && I_EXT_RESET |=> O_MODE == PMC_NORMAL && O_CPU_RESET)
        else $error("Reset did not end the mode.");
    a_timeout_exit: assert property (I_CE && (O_MODE == PMC_IDLE
        && I_WDT_EN && I_WDT_TIMEOUT || O_MODE == PMC_STOP && I_MCD_EN
        && I_MCD_TIMEOUT) |=> O_MODE == PMC_NORMAL && O_CPU_RESET)
        else $error("Timeout reset did not end the mode.");
    a_stop_hold: assert property (O_MODE == PMC_STOP && !any_rst
        |=> O_MODE == PMC_STOP)
        else $error("Stop left without a reset.");
    a_one_mode: assert property ($onehot(O_MODE)
        && O_CPU_HALT == (O_MODE != PMC_NORMAL) && O_WAKE_CONFIG[7:5] == 3'h0)
        else $error("Mode not one-hot or halt mismatch.");
    a_susp_gate: assert property (
        O_MODE inside {PMC_SUSPEND, PMC_SLEEP} |-> O_SYSCLK_GATE
        && O_PERIPH_FREEZE && !O_PREC_OSC_EN && !O_LP_OSC_EN)
        else $error("Suspend gating wrong.");
    a_stop_osc: assert property (O_MODE == PMC_STOP |-> !O_PREC_OSC_EN
        && O_LP_OSC_EN && !O_SYSCLK_GATE)
        else $error("Stop oscillator state wrong.");
    a_sleep_supply: assert property (
        O_SUPPLY_GATE == (O_MODE == PMC_SLEEP))
        else $error("Supply gate does not follow sleep.");
    a_flag_blank: assert property (wake_exit |->
        (O_WAKE_CONFIG[4:0] == 5'h00) [*3])
        else $error("Wake flags visible too early.");
    a_ce_freeze: assert property (!I_CE |=> $stable(O_MODE))
        else $error("Mode moved while clock enable low.");
endmodule
bind pmc_top pmc_asserts u_chk (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST),
    .I_CE(I_CE), .I_MODE_REQ(I_MODE_REQ), .I_INT_PENDING(I_INT_PENDING),
    .I_WDT_EN(I_WDT_EN), .I_WDT_TIMEOUT(I_WDT_TIMEOUT), .I_MCD_EN(I_MCD_EN),
    .I_MCD_TIMEOUT(I_MCD_TIMEOUT), .I_EXT_RESET(I_EXT_RESET),
    .O_MODE(O_MODE), .O_CPU_HALT(O_CPU_HALT), .O_CPU_RESET(O_CPU_RESET),
    .O_IDLE_SEL(O_IDLE_SEL), .O_SYSCLK_GATE(O_SYSCLK_GATE),
    .O_PREC_OSC_EN(O_PREC_OSC_EN), .O_LP_OSC_EN(O_LP_OSC_EN),
    .O_PERIPH_FREEZE(O_PERIPH_FREEZE), .O_INT_SERVICE(O_INT_SERVICE),
    .O_WAKE_CONFIG(O_WAKE_CONFIG), .O_SUPPLY_GATE(O_SUPPLY_GATE));

// ---- sim/pmc_far_model.sv ----
// Behavioural model of the CPU core strobes and the wake event sources.
// Assumes the bench calls its tasks; outputs change just after rising edges.
`timescale 1ns/1ps
module pmc_far_model
    import pmc_pkg::*;
(
    input  wire logic i_clk,
    output pmc_req_s  o_mode_req,
    output pmc_wake_s o_wake_evt,
    output logic      o_rst_pin_n,
    output logic      o_wake_clear
);
    logic pin_woke;
    initial begin
        o_mode_req = '0;
        o_wake_evt = '0;
        o_rst_pin_n = 1'b1;
        o_wake_clear = 1'b0;
        pin_woke = 1'b0;
    end
    // Firmware is assumed to have set the flash bypass and clock source.
    task automatic strobe(input pmc_req_s r, input logic clr);
        if (r.suspend || r.sleep) begin
            if (pin_woke) repeat (RST_WAKE_HOLD_CLKS) @(posedge i_clk);
            pin_woke = 1'b0;
            @(posedge i_clk);
            o_wake_clear <= clr;
            @(posedge i_clk);
            o_wake_clear <= 1'b0;
        end
        @(posedge i_clk);
        o_mode_req <= r;
        @(posedge i_clk);
        o_mode_req <= '0;
    endtask
    // A source holds its level a few clocks so the synchroniser sees it.
    task automatic fire(input int idx, input int hold);
        @(posedge i_clk);
        o_wake_evt[idx] <= 1'b1;
        repeat (hold) @(posedge i_clk);
        o_wake_evt[idx] <= 1'b0;
    endtask
    task automatic glitch(input int hold);
        @(posedge i_clk);
        o_rst_pin_n <= 1'b0;
        repeat (hold) @(posedge i_clk);
        o_rst_pin_n <= 1'b1;
        pin_woke = 1'b1;
    endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the power mode controller.
// Assumes the top, its bound checker and the far-side model compile first.
`timescale 1ns/1ps
module tb;
    import pmc_pkg::*;
    logic        clk, rst, ce, intp, wdt_en, wdt_to, mcd_en, mcd_to, ext_rst;
    logic        halt, cpu_rst, idle_sel, stop_sel, gate, prec, lp, frz;
    logic        isvc, from_pin, supply, wclr, pin_n;
    logic [3:0]  wen;
    logic [7:0]  cfg;
    logic [15:0] vec;
    pmc_req_s    req;
    pmc_wake_s   evt;
    pmc_mode_e   mode;
    int          mismatches, checks_done, seed, i, j, k;
    pmc_top dut (.I_REF_CLK(clk), .I_RST(rst), .I_CE(ce), .I_MODE_REQ(req),
        .I_WAKE_EN(wen), .I_WAKE_CLEAR(wclr), .I_INT_PENDING(intp),
        .I_WDT_EN(wdt_en), .I_WDT_TIMEOUT(wdt_to), .I_MCD_EN(mcd_en),
        .I_MCD_TIMEOUT(mcd_to), .I_EXT_RESET(ext_rst), .I_WAKE_EVT(evt),
        .I_RST_PIN_N(pin_n), .O_MODE(mode), .O_CPU_HALT(halt),
        .O_CPU_RESET(cpu_rst), .O_RESUME_VECTOR_SEL(vec),
        .O_IDLE_SEL(idle_sel), .O_STOP_SEL(stop_sel), .O_SYSCLK_GATE(gate),
        .O_PREC_OSC_EN(prec), .O_LP_OSC_EN(lp), .O_PERIPH_FREEZE(frz),
        .O_INT_SERVICE(isvc), .O_WAKE_CONFIG(cfg),
        .O_WAKE_FROM_RST_PIN(from_pin), .O_SUPPLY_GATE(supply));
    pmc_far_model far (.i_clk(clk), .o_mode_req(req), .o_wake_evt(evt),
        .o_rst_pin_n(pin_n), .o_wake_clear(wclr));
    function automatic logic [7:0] exp_cfg(input logic [3:0] f,
                                           input logic p);
        return {3'h0, p, f};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wait_mode(input pmc_mode_e m, input int lim);
        int n;
        n = 0;
        #1;
        while (mode !== m && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("mode", mode, m);
    endtask
    task automatic hold_mode(input pmc_mode_e m, input int n);
        repeat (n) @(posedge clk);
        #1;
        check("mode held", mode, m);
    endtask
    // Pulses one cause for a single sampled edge, then looks after it.
    task automatic hit(input int which);
        @(posedge clk);
        case (which)
            0: intp <= 1'b1;
            1: wdt_to <= 1'b1;
            2: mcd_to <= 1'b1;
            default: ext_rst <= 1'b1;
        endcase
        @(posedge clk);
        {intp, wdt_to, mcd_to, ext_rst} <= 4'h0;
        #1;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500000;
        mismatches++;
        finish_test();
    end
    initial begin
        seed = 41662;
        {rst, ce, intp, wdt_en, wdt_to, mcd_en, mcd_to, ext_rst} = 8'hc0;
        wen = 4'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check("reset", {mode, prec, lp, gate, cfg},
              {PMC_NORMAL, 11'h600});
        check("vector", vec, RESET_VECTOR);
        for (k = 0; k < 4; k++) begin
            far.strobe(4'h8, 1'b0);
            wait_mode(PMC_IDLE, 3);
            repeat ($unsigned($random(seed)) % 6) @(posedge clk);
            hit(0);
            check("int exit", {mode, idle_sel, isvc},
                  {PMC_NORMAL, 2'h1});
        end
        far.strobe(4'h8, 1'b0);
        far.strobe(4'h4, 1'b0);
        hold_mode(PMC_IDLE, 3);
        check("stop sel", stop_sel, 1'b0);
        hit(1);
        hold_mode(PMC_IDLE, 2);
        wdt_en <= 1'b1;
        hit(1);
        check("wdt exit", {mode, cpu_rst}, {PMC_NORMAL, 1'b1});
        far.strobe(4'h4, 1'b0);
        wait_mode(PMC_STOP, 3);
        check("stop osc", {prec, lp, stop_sel}, 3'h3);
        hit(0);
        hit(2);
        hold_mode(PMC_STOP, 2);
        mcd_en <= 1'b1;
        hit(2);
        check("mcd exit", {mode, cpu_rst}, {PMC_NORMAL, 1'b1});
        for (k = 0; k < 2; k++) begin
            far.strobe(k ? 4'h8 : 4'h4, 1'b0);
            hit(3);
            check("reset exit", {mode, cpu_rst}, {PMC_NORMAL, 1'b1});
        end
        ce <= 1'b0;
        far.strobe(4'h8, 1'b0);
        hold_mode(PMC_NORMAL, 2);
        ce <= 1'b1;
        for (k = 0; k < 4; k++) begin
            i = (k + $unsigned($random(seed))) % 4;
            j = (i + 1 + $unsigned($random(seed)) % 3) % 4;
            wen <= 4'h1 << i;
            far.strobe(k == 3 ? 4'h1 : 4'h2, 1'b1);
            wait_mode(k == 3 ? PMC_SLEEP : PMC_SUSPEND, 3);
            far.fire(j, 4);
            hold_mode(k == 3 ? PMC_SLEEP : PMC_SUSPEND, 6);
            far.fire(i, 4);
            wait_mode(PMC_NORMAL, 2);
            check("blank", cfg[4:0], 5'h00);
            hold_mode(PMC_NORMAL, 6);
            check("flags", cfg,
                  exp_cfg((4'h1 << i) | (4'h1 << j), 1'b0));
            far.strobe(4'h2, 1'b0);
            hold_mode(PMC_NORMAL, 4);
        end
        wen <= 4'h0;
        far.strobe(4'h2, 1'b1);
        wait_mode(PMC_SUSPEND, 3);
        far.glitch(3);
        wait_mode(PMC_NORMAL, 8);
        hold_mode(PMC_NORMAL, 5);
        check("pin wake", {from_pin, cfg[4]}, 2'h3);
        wen <= 4'h1;
        far.strobe(4'h2, 1'b1);
        wait_mode(PMC_SUSPEND, 3);
        far.fire(0, 4);
        wait_mode(PMC_NORMAL, 2);
        check("pin wake", from_pin, 1'b0);
        finish_test();
    end
endmodule
